// ### logic/reset_source_sequencer.v
// reset source combiner, stretch counter, cause flags and sleep gating
`timescale 1ns/10ps
`include "reset_seq_defs.vh"
module reset_source_sequencer #(
    parameter DELAY_W = 24,
    parameter [3:0] DELAY_SEL_W = 4
) (
    input wire aclk,
    input wire aresetn,
    input wire poweron_ok,
    input wire reset_pin_n,
    input wire watchdog_timeout,
    input wire watchdog_enable,
    input wire brownout_low,
    input wire brownout_enable_fuse,
    input wire brownout_level_fuse,
    input wire [3:0] clock_select_fuses,
    input wire [31:0] awaddr,
    input wire awvalid,
    output reg awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    input wire [31:0] araddr,
    input wire arvalid,
    output reg arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    output reg port_reset,
    output reg core_reset,
    output reg input_buffer_en,
    output reg adc_power_en,
    output reg adc_extended_conv,
    output reg acmp_power_en,
    output reg brownout_power_en,
    output reg watchdog_run_en,
    output reg vref_power_en,
    output reg brownout_level_sel
);
    // ==========================================================
    // input synchronisers
    // ==========================================================
    reg [3:0] sync1_q;
    reg [3:0] sync2_q;
    wire pwr_ok_s;
    wire pin_low_s;
    wire wdt_to_s;
    wire bod_low_s;

    // pins and detectors are asynchronous; two flops before use
    // only the second stage feeds logic, so a metastable first stage
    // gets a full cycle to settle before anything decodes it
    always @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= {watchdog_timeout, brownout_low, ~reset_pin_n,
                        poweron_ok};
            sync2_q <= sync1_q;
        end
    end
    // supply reads as failed until it has crossed both stages
    assign pwr_ok_s = sync2_q[0];
    assign pin_low_s = sync2_q[1];
    assign bod_low_s = sync2_q[2];
    assign wdt_to_s = sync2_q[3];

    // ==========================================================
    // source qualification
    // ==========================================================
    wire pin_src;
    wire bod_src;
    wire bod_raw;
    reg wdt_prev_q;
    reg wdt_pulse_q;

    // pin pulse must outlast the minimum width before it counts
    level_filter #(
        .COUNT(`PIN_MIN_CYC),
        .W(8)
    ) u_pin_filter (
        .aclk(aclk),
        .aresetn(aresetn),
        .level_in(pin_low_s),
        .level_out(pin_src)
    );

    // brown-out only when the fuse enables the detector
    assign bod_raw = bod_low_s & brownout_enable_fuse;

    // short dips below the trigger never reach the source
    level_filter #(
        .COUNT(`BOD_MIN_CYC),
        .W(8)
    ) u_bod_filter (
        .aclk(aclk),
        .aresetn(aresetn),
        .level_in(bod_raw),
        .level_out(bod_src)
    );

    // watchdog expiry becomes a single-cycle pulse when enabled
    // the enable is sampled with the edge, so a late enable misses it
    always @(posedge aclk) begin
        if (!aresetn) begin
            wdt_prev_q <= 1'b0;
            wdt_pulse_q <= 1'b0;
        end else begin
            wdt_prev_q <= wdt_to_s;
            wdt_pulse_q <= wdt_to_s & ~wdt_prev_q & watchdog_enable;
        end
    end

    // power loss needs no filter: reset must reassert at once
    wire pwr_src;
    wire any_src;
    assign pwr_src = ~pwr_ok_s;
    assign any_src = pwr_src | pin_src | bod_src | wdt_pulse_q;

    // ==========================================================
    // delay counter and reset outputs
    // ==========================================================
    reg [DELAY_W-1:0] delay_q;
    reg [DELAY_W-1:0] delay_len;

    // stretch length chosen from the clock select fuses
    // fuse values at or above the counter width shift the one out
    always @* begin
        delay_len = {{(DELAY_W-1){1'b0}}, 1'b1} << clock_select_fuses;
    end

    // the counter reloads on every cycle a source stands, so the stretch
    // is measured from the last source to clear, not the first
    // any active source reloads; count starts when all are gone
    always @(posedge aclk) begin
        if (!aresetn) begin
            delay_q <= {DELAY_W{1'b0}};
            port_reset <= 1'b1;
            core_reset <= 1'b1;
        end else if (any_src) begin
            delay_q <= delay_len;
            port_reset <= 1'b1;
            core_reset <= 1'b1;
        end else if (delay_q != {DELAY_W{1'b0}}) begin
            delay_q <= delay_q - 1'b1;
            port_reset <= 1'b1;
            core_reset <= 1'b1;
        end else begin
            port_reset <= 1'b0;
            core_reset <= 1'b0;
        end
    end
    // port_reset is exported raw so ports clear without a clock in silicon;
    // here it is registered to keep one domain

    // ==========================================================
    // cause flags
    // ==========================================================
    reg [3:0] cause_q;
    wire wr_cause;

    // hardware set wins over software clear in the same cycle
    // a zero write clears only the flags written as zero; ones keep theirs
    always @(posedge aclk) begin
        if (!aresetn) begin
            cause_q <= 4'h0;
        end else if (pwr_src) begin
            cause_q <= 4'h1;
        end else begin
            if (wr_cause && wstrb[0])
                cause_q <= cause_q & wdata[3:0];
            if (pin_src)
                cause_q[`FLAG_PIN] <= 1'b1;
            if (bod_src)
                cause_q[`FLAG_BOD] <= 1'b1;
            if (wdt_pulse_q)
                cause_q[`FLAG_WDT] <= 1'b1;
        end
    end

    // ==========================================================
    // control register and sleep gating
    // ==========================================================
    reg [7:0] ctrl_q;
    reg adc_prev_q;
    wire wr_ctrl;
    wire sleeping;
    wire [2:0] mode;
    wire light_sleep;

    // sleep mode decode; reserved codes behave as the deep modes
    assign sleeping = ctrl_q[`CTRL_SLEEP];
    assign mode = ctrl_q[`CTRL_MODE_HI:`CTRL_MODE_LO];
    assign light_sleep = (mode == `MODE_IDLE) || (mode == `MODE_ADCNR);

    // control bits return to defaults under any internal reset
    always @(posedge aclk) begin
        if (!aresetn || core_reset) begin
            ctrl_q <= `CTRL_RESET;
        end else if (wr_ctrl && wstrb[0]) begin
            ctrl_q <= wdata[7:0];
        end
    end

    // level fuse only steers the analog trigger; it is mirrored out
    // power enables; idle keeps I/O clock, noise reduction the ADC clock
    always @(posedge aclk) begin
        if (!aresetn) begin
            adc_prev_q <= 1'b0;
            input_buffer_en <= 1'b1;
            adc_power_en <= 1'b0;
            adc_extended_conv <= 1'b0;
            acmp_power_en <= 1'b0;
            brownout_power_en <= 1'b0;
            watchdog_run_en <= 1'b0;
            vref_power_en <= 1'b0;
            brownout_level_sel <= 1'b0;
        end else begin
            adc_prev_q <= ctrl_q[`CTRL_ADC_EN];
            input_buffer_en <= ~sleeping | light_sleep;
            adc_power_en <= ctrl_q[`CTRL_ADC_EN];
            // re-enable arms a long conversion; cleared when turned off
            if (ctrl_q[`CTRL_ADC_EN] && !adc_prev_q)
                adc_extended_conv <= 1'b1;
            else if (!ctrl_q[`CTRL_ADC_EN])
                adc_extended_conv <= 1'b0;
            acmp_power_en <= ctrl_q[`CTRL_ACMP_EN]
                             & (~sleeping | light_sleep);
            brownout_power_en <= brownout_enable_fuse;
            watchdog_run_en <= watchdog_enable;
            vref_power_en <= brownout_enable_fuse | ctrl_q[`CTRL_ADC_EN]
                             | (ctrl_q[`CTRL_ACMP_BG]
                                & ctrl_q[`CTRL_ACMP_EN]);
            brownout_level_sel <= brownout_level_fuse;
        end
    end

    // ==========================================================
    // AXI4-Lite slave
    // ==========================================================
    reg aw_have_q;
    reg w_have_q;
    reg [7:0] aw_addr_q;
    wire wr_fire;

    assign wr_fire = aw_have_q && w_have_q && !bvalid;
    assign wr_cause = wr_fire && (aw_addr_q == `REG_CAUSE_OFF);
    assign wr_ctrl = wr_fire && (aw_addr_q == `REG_CTRL_OFF);

    // only the low byte of the address is decoded; upper bits alias
    // write: address and data taken in either order, then response
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
        end else begin
            awready <= !aw_have_q && !awready && awvalid;
            wready <= !w_have_q && !wready && wvalid;
            if (awvalid && awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= {awaddr[7:2], 2'h0};
            end
            if (wvalid && wready)
                w_have_q <= 1'b1;
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid <= 1'b1;
                // state register is read-only; unmapped gives decode error
                bresp <= (aw_addr_q == `REG_CAUSE_OFF
                          || aw_addr_q == `REG_CTRL_OFF) ? 2'h0 :
                         (aw_addr_q == `REG_STATE_OFF) ? 2'h2 : 2'h3;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // a new address is refused while the previous answer still stands
    // read: one cycle to accept, data the next
    always @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= 2'h0;
        end else begin
            arready <= !arready && !rvalid && arvalid;
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rresp <= 2'h0;
                case ({araddr[7:2], 2'h0})
                    `REG_CAUSE_OFF: rdata <= {28'h0000000, cause_q};
                    `REG_CTRL_OFF: rdata <= {24'h000000, ctrl_q};
                    `REG_STATE_OFF: rdata <= {24'h000000, 3'h0,
                        adc_extended_conv, vref_power_en, input_buffer_en,
                        port_reset, core_reset};
                    default: begin
                        rdata <= 32'h0000_0000;
                        rresp <= 2'h3;
                    end
                endcase
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule

// ### logic/reset_seq_defs.vh
// constants for the reset source sequencer
`ifndef RESET_SEQ_DEFS_VH
`define RESET_SEQ_DEFS_VH
// register byte offsets
`define REG_CAUSE_OFF 8'h00
`define REG_CTRL_OFF 8'h04
`define REG_STATE_OFF 8'h08
// cause flag positions
`define FLAG_PWR 0
`define FLAG_PIN 1
`define FLAG_BOD 2
`define FLAG_WDT 3
// control register field positions
`define CTRL_ADC_EN 0
`define CTRL_ACMP_EN 1
`define CTRL_ACMP_BG 2
`define CTRL_SLEEP 3
`define CTRL_MODE_LO 4
`define CTRL_MODE_HI 6
`define CTRL_RESET 8'h00
// sleep mode encodings
`define MODE_IDLE 3'h0
`define MODE_ADCNR 3'h1
// times in ns and cycle counts at 100 ns per cycle
`define CLK_PERIOD_NS 100
`define BOD_MIN_NS 2000
`define BOD_MIN_CYC ((`BOD_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PIN_MIN_NS 1500
`define PIN_MIN_CYC ((`PIN_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ### logic/level_filter.v
// persistence filter: output rises only after a stable run, falls as soon as the input drops
`timescale 1ns/10ps
module level_filter #(
    parameter COUNT = 20,
    parameter W = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire level_in,
    output reg level_out
);
    reg [W-1:0] run_q;

    // count cycles the input is asserted; short dips never reach the end
    always @(posedge aclk) begin
        if (!aresetn) begin
            run_q <= {W{1'b0}};
            level_out <= 1'b0;
        end else if (!level_in) begin
            run_q <= {W{1'b0}};
            level_out <= 1'b0;
        end else if (run_q >= COUNT[W-1:0] - 1'b1) begin
            level_out <= 1'b1;
        end else begin
            run_q <= run_q + 1'b1;
        end
    end
endmodule

// ### testbench/reset_seq_assertions.sv
// port checker for the reset source sequencer
`timescale 1ns/10ps
module reset_seq_assertions (
    input wire aclk,
    input wire aresetn,
    input wire poweron_ok,
    input wire reset_pin_n,
    input wire watchdog_enable,
    input wire brownout_enable_fuse,
    input wire [31:0] araddr,
    input wire arvalid,
    input wire arready,
    input wire [31:0] rdata,
    input wire rvalid,
    input wire port_reset,
    input wire core_reset,
    input wire adc_power_en,
    input wire brownout_power_en,
    input wire watchdog_run_en,
    input wire vref_power_en
);
    reg [31:0] raddr_q;
    // ==========================================================
    // helpers
    // keep the read address so returned data is judged by place
    always @(posedge aclk) begin
        if (arvalid && arready)
            raddr_q <= araddr;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // after a pin release the stretch lasts sync plus delay cycles
    sequence s_held;
        core_reset [*5];
    endsequence
    // ==========================================================
    // properties
    AST_PORTRST: assert property ($fell(poweron_ok)
        |-> ##[1:3] port_reset) else $error("port reset late");
    AST_RSV: assert property (rvalid && raddr_q == 32'h0
        |-> rdata[31:4] == 28'h0) else $error("reserved cause bits set");
    AST_PWRLOSS: assert property ($fell(poweron_ok)
        |-> ##[1:3] core_reset) else $error("power loss not seen");
    AST_STRETCH: assert property ($fell(core_reset)
        |-> $past(poweron_ok, 4) && $past(reset_pin_n, 4))
        else $error("reset released too early");
    AST_PINREL: assert property ($rose(reset_pin_n) && core_reset
        |-> s_held) else $error("pin release cut the delay");
    AST_VREF: assert property (brownout_power_en || adc_power_en
        |-> ##[0:1] vref_power_en) else $error("reference off");
    AST_BODON: assert property (aresetn
        |=> brownout_power_en == $past(brownout_enable_fuse))
        else $error("detector power not following fuse");
    AST_WDRUN: assert property (aresetn
        |=> watchdog_run_en == $past(watchdog_enable))
        else $error("watchdog run not following enable");
endmodule
bind reset_source_sequencer reset_seq_assertions i_chk (.aclk, .aresetn,
    .poweron_ok, .reset_pin_n, .watchdog_enable, .brownout_enable_fuse,
    .araddr, .arvalid, .arready, .rdata, .rvalid, .port_reset, .core_reset,
    .adc_power_en, .brownout_power_en, .watchdog_run_en, .vref_power_en);

// ### testbench/reset_src_model.sv
// far side model: supply detectors, reset pin and watchdog timer
`timescale 1ns/10ps
module reset_src_model (
    input wire aclk,
    output wire poweron_ok,
    output wire reset_pin_n,
    output wire brownout_low,
    output wire watchdog_timeout
);
    // one bit per source, set while that source is active
    reg [3:0] active_q = 4'h1;
    // supply starts below threshold, as after a real power-up
    assign poweron_ok = !active_q[0];
    assign reset_pin_n = !active_q[1];
    assign brownout_low = active_q[2];
    assign watchdog_timeout = active_q[3];
    // activate one source for n cycles; changes land on clock edges
    task hold(input logic [1:0] s, input int n);
        begin
            @(posedge aclk);
            active_q[s] <= 1'b1;
            repeat (n) @(posedge aclk);
            active_q[s] <= 1'b0;
        end
    endtask
endmodule

// ### testbench/tb_top.sv
// self-checking bench for the reset source sequencer
`timescale 1ns/10ps
`include "reset_seq_defs.vh"
module tb_top;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic watchdog_enable, brownout_enable_fuse, brownout_level_fuse;
    logic [3:0] clock_select_fuses;
    logic [31:0] awaddr, wdata, araddr;
    wire poweron_ok, reset_pin_n, watchdog_timeout, brownout_low;
    wire awready, wready, bvalid, arready, rvalid, port_reset, core_reset;
    wire input_buffer_en, adc_power_en, adc_extended_conv, acmp_power_en;
    wire brownout_power_en, watchdog_run_en, vref_power_en;
    wire brownout_level_sel;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int err_count = 0;
    int n_compared = 0;
    // ==========================================================
    // design and far side
    // small delay fuse keeps the stretches short
    reset_source_sequencer i_dut (.aclk, .aresetn, .poweron_ok,
        .reset_pin_n, .watchdog_timeout, .watchdog_enable, .brownout_low,
        .brownout_enable_fuse, .brownout_level_fuse,
        .clock_select_fuses, .awaddr, .awvalid, .awready, .wdata,
        .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .port_reset,
        .core_reset, .input_buffer_en, .adc_power_en, .adc_extended_conv,
        .acmp_power_en, .brownout_power_en, .watchdog_run_en,
        .vref_power_en, .brownout_level_sel);
    reset_src_model i_src (.aclk, .poweron_ok, .reset_pin_n,
        .brownout_low, .watchdog_timeout);
    // ==========================================================
    // compare and bus tasks
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        begin
            n_compared++;
            if (g !== e) begin
                err_count++;
                $display("unexpected %s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task chkb(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask
    // address and data offered together, each dropped once taken
    task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        int k;
        begin
            @(posedge aclk);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            k = 0;
            for (n = 0; n < 50 && k < 2; n++) begin
                @(posedge aclk);
                if (awvalid && awready === 1'b1) begin
                    awvalid <= 1'b0;
                    k++;
                end
                if (wvalid && wready === 1'b1) begin
                    wvalid <= 1'b0;
                    k++;
                end
            end
            for (n = 0; n < 50 && bvalid !== 1'b1; n++)
                @(posedge aclk);
            bready <= 1'b0;
            chkb("bvalid", 1'b1, bvalid);
            chk("bresp", {30'h0, r}, {30'h0, bresp});
        end
    endtask
    // data is only judged on an okay answer
    task rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r);
        int n;
        begin
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            for (n = 0; n < 50 && arready !== 1'b1; n++)
                @(posedge aclk);
            arvalid <= 1'b0;
            for (n = 0; n < 50 && rvalid !== 1'b1; n++)
                @(posedge aclk);
            rready <= 1'b0;
            chkb("rvalid", 1'b1, rvalid);
            chk("rresp", {30'h0, r}, {30'h0, rresp});
            if (r == 2'h0)
                chk("rdata", e, rdata);
        end
    endtask
    // reset must be seen high, then released within the bound
    task rst_seen;
        int n;
        begin
            for (n = 0; n < 40 && core_reset !== 1'b1; n++)
                @(posedge aclk);
            chkb("core_reset", 1'b1, core_reset);
            for (n = 0; n < 300 && core_reset !== 1'b0; n++)
                @(posedge aclk);
            chkb("released", 1'b0, core_reset);
        end
    endtask
    // ==========================================================
    // scenarios
    task t_power;
        begin
            i_src.hold(2'h0, 20);
            rst_seen;
            rd(`REG_CAUSE_OFF, 32'h1, 2'h0);
            rd(`REG_CTRL_OFF, 32'h0, 2'h0);
            wr(`REG_CAUSE_OFF, 32'h0, 2'h0);
            rd(`REG_CAUSE_OFF, 32'h0, 2'h0);
            wr(`REG_STATE_OFF, 32'h0, 2'h2);
            rd(32'h10, 32'h0, 2'h3);
        end
    endtask
    task t_pin_bod;
        begin
            i_src.hold(2'h1, 5);
            i_src.hold(2'h2, 10);
            repeat (10) @(posedge aclk);
            rd(`REG_CAUSE_OFF, 32'h0, 2'h0);
            i_src.hold(2'h1, 25);
            rst_seen;
            rd(`REG_CAUSE_OFF, 32'h2, 2'h0);
            i_src.hold(2'h2, 40);
            rst_seen;
            rd(`REG_CAUSE_OFF, 32'h6, 2'h0);
        end
    endtask
    task t_wdt;
        begin
            i_src.hold(2'h3, 4);
            repeat (10) @(posedge aclk);
            rd(`REG_CAUSE_OFF, 32'h6, 2'h0);
            watchdog_enable <= 1'b1;
            i_src.hold(2'h3, 4);
            rst_seen;
            rd(`REG_CAUSE_OFF, 32'hE, 2'h0);
            i_src.hold(2'h0, 10);
            rst_seen;
            rd(`REG_CAUSE_OFF, 32'h1, 2'h0);
        end
    endtask
    // longer fuse: release comes two sync, load and output cycles past 2**5
    task t_delay;
        int n;
        begin
            clock_select_fuses <= 4'h5;
            i_src.hold(2'h0, 10);
            for (n = 0; n < 300 && core_reset !== 1'b0; n++)
                @(posedge aclk);
            chk("stretch", (32'h1 << 5) + 32'h4, n);
            rd(`REG_CAUSE_OFF, 32'h1, 2'h0);
        end
    endtask
    // sleep with adc and comparator on, through the first four modes
    task t_sleep;
        int m;
        begin
            brownout_enable_fuse <= 1'b0;
            brownout_level_fuse <= 1'b1;
            for (m = 0; m < 4; m++) begin
                wr(`REG_CTRL_OFF, (m << 4) | 32'hB, 2'h0);
                repeat (2) @(posedge aclk);
                chkb("in_buf", m < 2, input_buffer_en);
                chkb("acmp", m < 2, acmp_power_en);
                chkb("adc", 1'b1, adc_power_en);
                chkb("vref", 1'b1, vref_power_en);
            end
            chkb("bod_level", 1'b1, brownout_level_sel);
            chkb("bod_pwr", 1'b0, brownout_power_en);
            wr(`REG_CTRL_OFF, 32'h0, 2'h0);
            repeat (2) @(posedge aclk);
            chkb("vref_off", 1'b0, vref_power_en);
            wr(`REG_CTRL_OFF, 32'h1, 2'h0);
            repeat (2) @(posedge aclk);
            chkb("ext_conv", 1'b1, adc_extended_conv);
        end
    endtask
    task finish_test;
        begin
            $display("compared %0d mismatches %0d", n_compared, err_count);
            if (err_count == 0 && n_compared > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    // ==========================================================
    // clock, sequence and watchdog
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        watchdog_enable = 1'b0;
        brownout_enable_fuse = 1'b1;
        {awaddr, wdata, araddr} = 96'h0;
        brownout_level_fuse = 1'b0;
        clock_select_fuses = 4'h2;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_power;
        t_pin_bod;
        t_wdt;
        t_delay;
        t_sleep;
        finish_test;
    end
    // far above the few hundred cycles the scenarios need
    initial begin
        repeat (5000) @(posedge aclk);
        err_count++;
        finish_test;
    end
endmodule
